// file: bff_defines.svh
// Constants of the breaker failure scheme
`ifndef BFF_DEFINES_SVH
`define BFF_DEFINES_SVH
`define BFF_NUM_INST 2
`define BFF_NUM_POLE 3
`define BFF_AMP_W 16
`define BFF_TIME_W 16
`define BFF_CLK_PERIOD_NS 20
`define BFF_TICK_PERIOD_MS 1
`define BFF_NS_PER_MS 1000000
`define BFF_TICK_CYCLES (`BFF_TICK_PERIOD_MS * `BFF_NS_PER_MS / `BFF_CLK_PERIOD_NS)
`define BFF_TICK_CNT_W 16
`define BFF_TIME_RST 16'h0000
`endif

// file: bff_pkg.sv
// Types of the breaker failure scheme
`include "bff_defines.svh"
package bff_pkg;
   typedef logic [`BFF_AMP_W-1:0] bff_amp_type;
   typedef logic [`BFF_TIME_W-1:0] bff_time_type;
   // Settings of one instance; thresholds in 0.001 pu, delays in ms
   typedef struct packed {
      logic scheme_enable;
      logic single_pole_scheme;
      logic use_current_supervised_initiate;
      logic use_initiate_latch;
      logic early_path_enable;
      logic main_path_enable;
      logic slow_path_enable;
      bff_amp_type phase_supervision_threshold;
      bff_amp_type neutral_supervision_threshold;
      bff_amp_type phase_high_threshold;
      bff_amp_type neutral_high_threshold;
      bff_amp_type phase_low_threshold;
      bff_amp_type neutral_low_threshold;
      bff_time_type early_delay;
      bff_time_type main_delay;
      bff_time_type slow_delay;
      bff_time_type low_set_delay;
      bff_time_type trip_dropout_delay;
   } bff_settings_type;
   typedef struct packed {
      logic three_pole_initiate_input;
      logic [`BFF_NUM_POLE-1:0] pole_initiate_input;
      logic scheme_block_input;
      logic [`BFF_NUM_POLE-1:0] fast_aux_contact_input;
      logic [`BFF_NUM_POLE-1:0] normal_aux_contact_input;
      logic out_of_service_input;
      logic target_reset;
   } bff_operands_type;
   typedef struct packed {
      bff_amp_type [`BFF_NUM_POLE-1:0] phase;
      bff_amp_type neutral;
   } bff_currents_type;
   typedef struct packed {
      logic [`BFF_NUM_POLE-1:0] retrip;
      logic trip;
      logic target;
      logic [`BFF_NUM_POLE-1:0] phase_indicator;
      logic [`BFF_NUM_POLE-1:0] initiated;
      logic [`BFF_NUM_POLE-1:0] early_op;
      logic [`BFF_NUM_POLE-1:0] main_op;
      logic [`BFF_NUM_POLE-1:0] slow_op;
      logic [`BFF_NUM_POLE-1:0] low_set_active;
   } bff_status_type;
endpackage

// file: bff_scheme.sv
// Breaker failure scheme: two instances and their shared millisecond tick
//
// How it works
// R1: Two identical independently set breaker failure instances, numbered one and two.
// R2: Mode picks three-pole or single-pole scheme; same logic for both.
// R3: Stages are initiation, failure determination, then outputs.
// R4: Latched initiate holds only while current supervision is picked up.
// R5: Optional current supervision blocks initiation below phase or neutral pickup.
// R6: Block input inhibits the scheme and resets an incomplete sequence.
// R7: Initiation immediately raises re-trip toward the signalled breaker.
// R8: Three timed paths; any timing out with conditions met declares failure and trip.
// R9: Each path has its own enable.
// R10: Early path needs fast contact closed and fault current after timer 1.
// R11: Main path needs fault current after timer 2, no contact check.
// R12: Timer 1 or 2 timeout enables Hi-set, then Lo-set after a delay.
// R13: Current detectors of early and main paths count only after timeout.
// R14: Slow path gated by contact and service switch, no current check.
// R15: Path delays 0 to 65.535 s in 1 ms steps.
// R16: Current thresholds 0.001 to 30.000 pu in 0.001 pu steps.
// R17: Trip output held for a programmable dropout time after failure.
// R18: Failure raises target and trip, per-phase indicators in single-pole mode only, plus status outputs.
// R19: Supervised initiation only while current exceeds supervision pickup.
// R20: Seal-in only while current exceeds supervision pickup.
// R21: Neutral supervision and thresholds used only in three-pole scheme.
// R22: Single-pole mode replicates per-pole logic with shared detector settings.
// R23: Detector picks up when magnitude is at least its threshold.
// R24: Timers step on a 1 ms tick and clear when their enable drops.
`timescale 1ns/100ps
`include "bff_defines.svh"

module bff_instance (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic tick_ms,
   // Settings, operands and measured magnitudes
   input wire bff_pkg::bff_settings_type set,
   input wire bff_pkg::bff_operands_type op,
   input wire bff_pkg::bff_currents_type cur,
   // Outputs
   output bff_pkg::bff_status_type st_q
);
   localparam int NP = `BFF_NUM_POLE;
   typedef bff_pkg::bff_time_type tm_t;

   // In three-pole mode pole 0 carries the whole breaker
   function automatic logic det(input bff_pkg::bff_currents_type c,
      input bff_pkg::bff_amp_type pth, input bff_pkg::bff_amp_type nth,
      input logic sp, input int p);
      if (sp) begin
         return c.phase[p] >= pth; // [R22] [R23]
      end
      return (c.phase[0] >= pth) | (c.phase[1] >= pth) | (c.phase[2] >= pth)
         | (c.neutral >= nth); // [R16] [R21] [R23]
   endfunction

   logic [NP-1:0] ini, run, sup_ok, hi_ok, lo_ok, fast_ax, norm_ax;
   logic [NP-1:0] ini_ok, active, done1, done2, done3, lo_sel, cur_ok;
   logic [NP-1:0] early, main_p, slow;
   logic [NP-1:0] seal_q;
   tm_t t1_q [NP];
   tm_t t2_q [NP];
   tm_t t3_q [NP];
   tm_t lo_q [NP];
   tm_t drop_q;
   logic fail;

   always_comb begin
      for (int p = 0; p < NP; p++) begin
         ini[p] = set.single_pole_scheme ? op.pole_initiate_input[p]
            : (p == 0) & op.three_pole_initiate_input; // [R2] [R22]
         run[p] = set.scheme_enable & ~op.scheme_block_input
            & (set.single_pole_scheme | (p == 0)); // [R6] [R1]
         fast_ax[p] = op.fast_aux_contact_input[set.single_pole_scheme ? p : 0];
         norm_ax[p] = op.normal_aux_contact_input[set.single_pole_scheme ? p : 0];
         sup_ok[p] = det(cur, set.phase_supervision_threshold,
            set.neutral_supervision_threshold, set.single_pole_scheme, p);
         hi_ok[p] = det(cur, set.phase_high_threshold,
            set.neutral_high_threshold, set.single_pole_scheme, p);
         lo_ok[p] = det(cur, set.phase_low_threshold,
            set.neutral_low_threshold, set.single_pole_scheme, p);
         ini_ok[p] = ini[p] & (~set.use_current_supervised_initiate | sup_ok[p]); // [R5] [R19]
         active[p] = run[p] & (ini_ok[p] | seal_q[p]); // [R3]
         done1[p] = active[p] & set.early_path_enable & (t1_q[p] >= set.early_delay); // [R9]
         done2[p] = active[p] & set.main_path_enable & (t2_q[p] >= set.main_delay); // [R9]
         done3[p] = active[p] & set.slow_path_enable & norm_ax[p]
            & ~op.out_of_service_input & (t3_q[p] >= set.slow_delay); // [R14]
         lo_sel[p] = (done1[p] | done2[p]) & (lo_q[p] >= set.low_set_delay); // [R12]
         // Detectors are looked at only once a path has timed out
         cur_ok[p] = lo_sel[p] ? lo_ok[p] : hi_ok[p]; // [R12] [R13]
         early[p] = done1[p] & fast_ax[p] & cur_ok[p]; // [R10]
         main_p[p] = done2[p] & cur_ok[p]; // [R11]
         slow[p] = done3[p]; // [R14]
      end
      fail = |(early | main_p | slow); // [R8]
   end

   // Seal-in falls as soon as supervision current goes away
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         seal_q <= '0;
      end else begin
         for (int p = 0; p < NP; p++) begin
            seal_q[p] <= run[p] & set.use_initiate_latch & (ini_ok[p] | seal_q[p])
               & sup_ok[p]; // [R4] [R20] [R6]
         end
      end
   end

   // Path timers, ms resolution, saturating at their setting
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (int p = 0; p < NP; p++) begin
            t1_q[p] <= `BFF_TIME_RST;
            t2_q[p] <= `BFF_TIME_RST;
            t3_q[p] <= `BFF_TIME_RST;
            lo_q[p] <= `BFF_TIME_RST;
         end
      end else begin
         for (int p = 0; p < NP; p++) begin
            if (!(active[p] & set.early_path_enable)) begin
               t1_q[p] <= `BFF_TIME_RST; // [R24]
            end else if (tick_ms & !done1[p]) begin
               t1_q[p] <= tm_t'(t1_q[p] + 1'b1); // [R15] [R24]
            end
            if (!(active[p] & set.main_path_enable)) begin
               t2_q[p] <= `BFF_TIME_RST; // [R24]
            end else if (tick_ms & !done2[p]) begin
               t2_q[p] <= tm_t'(t2_q[p] + 1'b1); // [R15] [R24]
            end
            if (!(active[p] & set.slow_path_enable & norm_ax[p]
                  & ~op.out_of_service_input)) begin
               t3_q[p] <= `BFF_TIME_RST; // [R14] [R24]
            end else if (tick_ms & !done3[p]) begin
               t3_q[p] <= tm_t'(t3_q[p] + 1'b1); // [R15] [R24]
            end
            if (!(done1[p] | done2[p])) begin
               lo_q[p] <= `BFF_TIME_RST; // [R24]
            end else if (tick_ms & !lo_sel[p]) begin
               lo_q[p] <= tm_t'(lo_q[p] + 1'b1); // [R12]
            end
         end
      end
   end

   // Trip with dropout hold; the dropout count restarts while failure stands
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_q.trip <= 1'b0;
         drop_q <= `BFF_TIME_RST;
      end else if (fail) begin
         st_q.trip <= 1'b1; // [R8]
         drop_q <= `BFF_TIME_RST;
      end else if (st_q.trip) begin
         if (drop_q >= set.trip_dropout_delay) begin
            st_q.trip <= 1'b0; // [R17]
         end else if (tick_ms) begin
            drop_q <= tm_t'(drop_q + 1'b1); // [R17]
         end
      end
   end

   // Indicators stick until reset; a new failure wins over the reset
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_q.target <= 1'b0;
         st_q.phase_indicator <= '0;
      end else begin
         st_q.target <= fail | (st_q.target & ~op.target_reset); // [R18]
         for (int p = 0; p < NP; p++) begin
            st_q.phase_indicator[p] <= (set.single_pole_scheme
               & (early[p] | main_p[p] | slow[p]))
               | (st_q.phase_indicator[p] & ~op.target_reset); // [R18]
         end
      end
   end

   // Status outputs
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st_q.retrip <= '0;
         st_q.initiated <= '0;
         st_q.early_op <= '0;
         st_q.main_op <= '0;
         st_q.slow_op <= '0;
         st_q.low_set_active <= '0;
      end else begin
         st_q.retrip <= active; // [R7]
         st_q.initiated <= active; // [R18]
         st_q.early_op <= early; // [R18]
         st_q.main_op <= main_p; // [R18]
         st_q.slow_op <= slow; // [R18]
         st_q.low_set_active <= lo_sel; // [R18]
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_fail_ends;
      fail ##1 !fail;
   endsequence

   AST_RETRIP_FOLLOWS: assert property (active[0] |=> st_q.retrip[0]) // [R7]
      else $error("re-trip missing after initiation");
   AST_BLOCK_CLEARS: assert property (op.scheme_block_input |=> st_q.retrip == '0) // [R6]
      else $error("re-trip while blocked");
   AST_SEAL_DROPS: assert property (!sup_ok[0] |=> !seal_q[0]) // [R4]
      else $error("seal-in held without current");
   AST_SUPV_INIT: assert property ((set.use_current_supervised_initiate & !seal_q[0]
      & !sup_ok[0]) |-> !active[0]) // [R5]
      else $error("initiated below supervision pickup");
   AST_FAIL_TRIP: assert property (fail |=> st_q.trip && st_q.target) // [R8]
      else $error("failure did not trip");
   AST_EARLY_GATE: assert property ($rose(st_q.early_op[0]) |-> $past(fast_ax[0])) // [R10]
      else $error("early path without closed contact");
   AST_SLOW_OOS: assert property (op.out_of_service_input |=> st_q.slow_op == '0) // [R14]
      else $error("slow path while out of service");
   AST_TIMER_RESET: assert property (!active[0] |=> t1_q[0] == `BFF_TIME_RST) // [R24]
      else $error("timer 1 not cleared");
   AST_PATH_OFF: assert property (!set.main_path_enable |=> st_q.main_op == '0) // [R9]
      else $error("disabled main path operated");
   AST_TRIP_HOLD: assert property ((s_fail_ends ##0 (set.trip_dropout_delay != '0))
      |-> st_q.trip) // [R17]
      else $error("trip dropped before dropout delay");
endmodule

module bff_scheme #(
   parameter int TICK_CYCLES = `BFF_TICK_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Per-instance settings, operands and currents
   input wire bff_pkg::bff_settings_type [`BFF_NUM_INST-1:0] settings,
   input wire bff_pkg::bff_operands_type [`BFF_NUM_INST-1:0] operands,
   input wire bff_pkg::bff_currents_type [`BFF_NUM_INST-1:0] currents,
   // Per-instance outputs
   output bff_pkg::bff_status_type [`BFF_NUM_INST-1:0] status
);
   logic [`BFF_TICK_CNT_W-1:0] tick_cnt_q;
   logic tick_q;

   // One shared tick keeps both instances on the same time base
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == `BFF_TICK_CNT_W'(TICK_CYCLES - 1)) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b1; // [R24]
      end else begin
         tick_cnt_q <= `BFF_TICK_CNT_W'(tick_cnt_q + 1'b1);
         tick_q <= 1'b0;
      end
   end

   for (genvar i = 0; i < `BFF_NUM_INST; i++) begin : g_inst
      bff_instance u_inst ( // [R1]
         .clk_sys(clk_sys),
         .resetn(resetn),
         .tick_ms(tick_q),
         .set(settings[i]),
         .op(operands[i]),
         .cur(currents[i]),
         .st_q(status[i])
      );
   end
endmodule

// file: bff_breaker_model.sv
// Breaker with auxiliary contact, answering the re-trip command
`timescale 1ns/100ps
module bff_breaker_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Trip command and breaker health
   input wire logic retrip,
   input wire logic healthy,
   // Auxiliary contact, 1 = breaker closed
   output logic aux_q
);
   logic [3:0] cnt_q;
   // A healthy breaker opens some cycles after the trip; a failed one stays closed.
   // Recloses once the trip drops, standing in for the reclosing scheme.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 4'h0;
         aux_q <= 1'b1;
      end else if (!retrip) begin
         cnt_q <= 4'h0;
         aux_q <= 1'b1;
      end else if (healthy && cnt_q == 4'h5) begin
         aux_q <= 1'b0;
      end else if (healthy) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule

// file: bff_scheme_tb.sv
// Self-checking bench of the breaker failure scheme
`timescale 1ns/100ps
`include "bff_defines.svh"
module bff_scheme_tb;
   localparam logic [15:0] THR = 16'h041a;
   logic clk_sys;
   logic resetn;
   bff_pkg::bff_settings_type [`BFF_NUM_INST-1:0] settings;
   bff_pkg::bff_operands_type [`BFF_NUM_INST-1:0] operands;
   bff_pkg::bff_currents_type [`BFF_NUM_INST-1:0] currents;
   bff_pkg::bff_status_type [`BFF_NUM_INST-1:0] status;
   bff_pkg::bff_settings_type cfg;
   bff_pkg::bff_currents_type cur;
   logic init, blk, oos, trst, healthy, aux;
   logic [2:0] pin;
   int failures;
   int n_tests;
   // Shortened tick keeps the millisecond timers inside a short run
   bff_scheme #(.TICK_CYCLES(10)) dut (.clk_sys(clk_sys), .resetn(resetn),
      .settings(settings), .operands(operands), .currents(currents), .status(status));
   bff_breaker_model brk (.clk_sys(clk_sys), .resetn(resetn), .retrip(status[0].retrip[0]),
      .healthy(healthy), .aux_q(aux));
   // Instance two shares settings and currents but is never initiated
   assign settings = {cfg, cfg};
   assign currents = {cur, cur};
   always_comb begin
      operands = '0;
      operands[0].three_pole_initiate_input = init;
      operands[0].pole_initiate_input = pin;
      operands[0].scheme_block_input = blk;
      operands[0].fast_aux_contact_input = {2'h0, aux};
      operands[0].normal_aux_contact_input = {2'h0, aux};
      operands[0].out_of_service_input = oos;
      operands[0].target_reset = trst;
   end
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic chk(input string name, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
         failures++;
      end
   endtask
   task automatic finish_test();
      if (failures == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wait_trip(input int n);
      int k;
      k = 0;
      while (status[0].trip !== 1'b1 && k < n) begin
         cyc(1);
         k++;
      end
      if (status[0].trip !== 1'b1) begin
         chk("trip in time", 1'b1, status[0].trip);
         finish_test();
      end
   endtask
   task automatic setup(input logic e, m, s, sup, hl, input logic [15:0] d);
      @(negedge clk_sys);
      init = 1'b0;
      blk = 1'b0;
      oos = 1'b0;
      trst = 1'b1;
      healthy = hl;
      pin = 3'h0;
      cur = '0;
      cfg = '0;
      cfg.scheme_enable = 1'b1;
      cfg.use_current_supervised_initiate = sup;
      cfg.early_path_enable = e;
      cfg.main_path_enable = m;
      cfg.slow_path_enable = s;
      cfg.phase_supervision_threshold = THR;
      cfg.neutral_supervision_threshold = THR;
      cfg.phase_high_threshold = THR;
      cfg.neutral_high_threshold = THR;
      cfg.phase_low_threshold = THR;
      cfg.neutral_low_threshold = THR;
      cfg.early_delay = d;
      cfg.main_delay = d;
      cfg.slow_delay = d;
      cyc(3);
      trst = 1'b0;
      cyc(2);
   endtask
   task automatic s_direct();
      setup(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0000);
      cur.phase[0] = THR;
      init = 1'b1;
      cyc(3);
      chk("retrip", 1'b1, status[0].retrip[0]);
      chk("trip", 1'b1, status[0].trip);
      chk("target", 1'b1, status[0].target);
      chk("trip two", 1'b0, status[1].trip);
      blk = 1'b1;
      cyc(3);
      chk("retrip blocked", 1'b0, status[0].retrip[0]);
      chk("trip blocked", 1'b0, status[0].trip);
      chk("target sticky", 1'b1, status[0].target);
      trst = 1'b1;
      cyc(2);
      chk("target cleared", 1'b0, status[0].target);
   endtask
   task automatic s_supv();
      setup(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0000);
      cur.phase[0] = THR - 16'h0001;
      init = 1'b1;
      cyc(3);
      chk("retrip below", 1'b0, status[0].retrip[0]);
      cur.phase[0] = THR;
      cyc(3);
      chk("retrip at pickup", 1'b1, status[0].retrip[0]);
      chk("main trip", 1'b1, status[0].trip);
   endtask
   task automatic s_early();
      setup(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0003);
      cur.phase[0] = THR;
      init = 1'b1;
      cyc(18);
      chk("trip timing", 1'b0, status[0].trip);
      wait_trip(20);
      chk("early op", 1'b1, status[0].early_op[0]);
      chk("main off", 1'b0, status[0].main_op[0]);
      setup(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0003);
      cur.phase[0] = THR;
      init = 1'b1;
      cyc(45);
      chk("trip contact open", 1'b0, status[0].trip);
   endtask
   task automatic s_main();
      setup(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0003);
      cur.phase[0] = THR - 16'h0001;
      init = 1'b1;
      cyc(45);
      chk("trip low current", 1'b0, status[0].trip);
      cur.phase[0] = THR;
      cyc(3);
      chk("trip open breaker", 1'b1, status[0].trip);
      init = 1'b0;
      cur.phase[0] = 16'h0000;
      cyc(4);
      chk("trip dropout", 1'b0, status[0].trip);
   endtask
   task automatic s_slow();
      setup(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0003);
      cur.phase[0] = 16'h0000;
      oos = 1'b1;
      init = 1'b1;
      cyc(45);
      chk("trip out of service", 1'b0, status[0].trip);
      oos = 1'b0;
      wait_trip(40);
      chk("slow op", 1'b1, status[0].slow_op[0]);
   endtask
   // Neutral pickup counts only in three-pole mode; single-pole keeps poles apart
   task automatic s_pole();
      setup(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0000);
      cur.neutral = THR;
      init = 1'b1;
      cyc(3);
      chk("neutral supv", 1'b1, status[0].retrip[0]);
      init = 1'b0;
      cfg.single_pole_scheme = 1'b1;
      pin = 3'b001;
      cyc(3);
      chk("neutral ignored", 1'b0, status[0].retrip[0]);
      cur.phase[1] = THR;
      pin = 3'b010;
      cyc(3);
      chk("pole b retrip", 1'b1, status[0].retrip[1]);
      chk("pole a idle", 1'b0, status[0].retrip[0]);
      chk("pole b main op", 1'b1, status[0].main_op[1]);
      chk("pole trip", 1'b1, status[0].trip);
      chk("pole b indicator", 1'b1, status[0].phase_indicator[1]);
      chk("pole a indicator", 1'b0, status[0].phase_indicator[0]);
   endtask
   task automatic s_latch();
      setup(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
      cfg.use_initiate_latch = 1'b1;
      cur.phase[0] = THR;
      init = 1'b1;
      cyc(2);
      init = 1'b0;
      cyc(3);
      chk("sealed retrip", 1'b1, status[0].retrip[0]);
      chk("initiated", 1'b1, status[0].initiated[0]);
      cur.phase[0] = THR - 16'h0001;
      cyc(3);
      chk("seal released", 1'b0, status[0].retrip[0]);
   endtask
   // Current sits between the two levels, so only the lower one can trip
   task automatic s_lowset();
      setup(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
      cfg.phase_high_threshold = THR + 16'h0100;
      cfg.low_set_delay = 16'h0002;
      cfg.trip_dropout_delay = 16'h0002;
      cur.phase[0] = THR;
      init = 1'b1;
      cyc(3);
      chk("hi set trip", 1'b0, status[0].trip);
      chk("low set idle", 1'b0, status[0].low_set_active[0]);
      wait_trip(30);
      chk("low set active", 1'b1, status[0].low_set_active[0]);
      init = 1'b0;
      cyc(3);
      chk("trip held", 1'b1, status[0].trip);
      cyc(25);
      chk("trip released", 1'b0, status[0].trip);
   endtask
   initial begin
      failures = 0;
      n_tests = 0;
      resetn = 1'b0;
      init = 1'b0;
      blk = 1'b0;
      oos = 1'b0;
      trst = 1'b0;
      healthy = 1'b0;
      pin = 3'h0;
      cfg = '0;
      cur = '0;
      cyc(20);
      resetn = 1'b1;
      s_direct();
      s_supv();
      s_early();
      s_main();
      s_slow();
      s_pole();
      s_latch();
      s_lowset();
      finish_test();
   end
endmodule
